// ### include/ces_pkg.sv
// Shared constants and types for the core event source block
package ces_pkg;
   localparam int WORD_W       = 32;
   localparam int CMDQ_DEPTH   = 16;
   localparam int INMBOX_DEPTH = 4;
   localparam int OUTMBOX_NUM  = 2;
   localparam int OUT_INTR_IDX = 1;
   localparam int SIG_NUM      = 2;
   localparam int CLASS_W      = 8;
   localparam int OPCODE_W     = 16;
   localparam int ADDR_W       = 64;
   localparam int LINE_BITS    = 7;
   // Event vector bit positions
   localparam int EVT_NUM      = 6;
   localparam int EVT_CMDQ     = 0;
   localparam int EVT_INMBOX   = 1;
   localparam int EVT_SIG1     = 2;
   localparam int EVT_SIG2     = 3;
   localparam int EVT_RESV     = 4;
   localparam int EVT_ATTN     = 5;
   localparam logic [EVT_NUM-1:0] EVT_RST = 6'h00;
   localparam logic [WORD_W-1:0]  WORD_RST = 32'h00000000;
   // Command word written by the core
   typedef struct packed {
      logic [CLASS_W-1:0]  class_id;
      logic [OPCODE_W-1:0] opcode;
   } ces_cmd_t;
endpackage

// ### hw/ces_core_events.sv
// Event sources, command queue, mailboxes and signal registers of the attached core

module ces_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  wire logic                       clk_sys,
   input  wire logic                       sys_rst,
   input  wire logic                       clk_en,
   input  wire logic                       in_valid,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            in_ready,
   output logic                            out_valid,
   output logic [WIDTH-1:0]                out_data,
   input  wire logic                       out_ready,
   output logic [$clog2(DEPTH+1)-1:0]      count
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [CW-1:0]    cnt_r;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   // Full stalls the writer, empty stalls the reader
   assign in_ready  = (cnt_r != CW'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rd_ptr_r];
   assign count     = cnt_r;
   assign push      = clk_en && in_valid && in_ready;
   assign pop       = clk_en && out_valid && out_ready;

   // Storage, written only at the tail so order is kept
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= ptr_inc(wr_ptr_r);
         end
         if (pop) begin
            rd_ptr_r <= ptr_inc(rd_ptr_r);
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + CW'(1);
         end else if (pop && !push) begin
            cnt_r <= cnt_r - CW'(1);
         end
      end
   end
endmodule

module ces_core_events #(
   parameter int ADDR_BITS = ces_pkg::ADDR_W,
   parameter int LINE_LSB  = ces_pkg::LINE_BITS
) (
   input  wire logic                                              clk_sys,
   input  wire logic                                              sys_rst,
   input  wire logic                                              clk_en,
   // Core command channel
   input  wire logic                                              cmd_wr_valid,
   input  wire ces_pkg::ces_cmd_t                                 cmd_wr,
   output logic                                                   cmd_wr_ready,
   output logic                                                   cmd_issue_valid,
   output ces_pkg::ces_cmd_t                                      cmd_issue,
   input  wire logic                                              cmd_issue_ready,
   // Inbound mailbox, MMIO side and core side
   input  wire logic                                              inmbox_wr_valid,
   input  wire logic [ces_pkg::WORD_W-1:0]                        inmbox_wr_data,
   output logic                                                   inmbox_wr_ready,
   input  wire logic                                              inmbox_rd,
   output logic [ces_pkg::WORD_W-1:0]                             inmbox_rd_data,
   output logic [$clog2(ces_pkg::INMBOX_DEPTH+1)-1:0]             inmbox_count,
   // Outbound mailboxes, core writes and host reads
   input  wire logic [ces_pkg::OUTMBOX_NUM-1:0]                   outmbox_wr,
   input  wire logic [ces_pkg::OUTMBOX_NUM-1:0][ces_pkg::WORD_W-1:0] outmbox_wr_data,
   output logic [ces_pkg::OUTMBOX_NUM-1:0]                        outmbox_wr_ready,
   input  wire logic [ces_pkg::OUTMBOX_NUM-1:0]                   outmbox_rd,
   output logic [ces_pkg::OUTMBOX_NUM-1:0][ces_pkg::WORD_W-1:0]   outmbox_data,
   output logic [ces_pkg::OUTMBOX_NUM-1:0]                        outmbox_full,
   output logic                                                   host_irq,
   // Signal registers, MMIO writes and core reads
   input  wire logic [ces_pkg::SIG_NUM-1:0]                       sig_or_mode,
   input  wire logic [ces_pkg::SIG_NUM-1:0]                       sig_wr,
   input  wire logic [ces_pkg::SIG_NUM-1:0][ces_pkg::WORD_W-1:0]  sig_wr_data,
   input  wire logic [ces_pkg::SIG_NUM-1:0]                       sig_rd,
   output logic [ces_pkg::WORD_W-1:0]                             sig_rd_data,
   output logic [ces_pkg::SIG_NUM-1:0]                            sig_waiting,
   // Line reservation and snooped outside writes
   input  wire logic                                              resv_set,
   input  wire logic [ADDR_BITS-1:0]                              resv_addr,
   input  wire logic                                              snoop_wr_valid,
   input  wire logic [ADDR_BITS-1:0]                              snoop_wr_addr,
   output logic                                                   resv_valid,
   // Privileged attention and event flags
   input  wire logic                                              attn_set,
   input  wire logic [ces_pkg::EVT_NUM-1:0]                       evt_ack,
   output logic [ces_pkg::EVT_NUM-1:0]                            evt_pending
);
   import ces_pkg::*;

   logic [EVT_NUM-1:0]              evt_pending_r;
   logic [EVT_NUM-1:0]              evt_set;
   logic [$clog2(CMDQ_DEPTH+1)-1:0] cmdq_cnt;
   logic                            cmdq_pop;
   logic                            inmbox_push;
   logic                            inmbox_valid;
   logic [WORD_W-1:0]               inmbox_head;
   logic [WORD_W-1:0]               inmbox_rd_data_r;
   logic [SIG_NUM-1:0][WORD_W-1:0]  sig_val_r;
   logic [WORD_W-1:0]               sig_rd_data_r;
   logic [OUTMBOX_NUM-1:0]          outmbox_full_r;
   logic [OUTMBOX_NUM-1:0][WORD_W-1:0] outmbox_data_r;
   logic                            resv_valid_r;
   logic [ADDR_BITS-LINE_LSB-1:0]   resv_line_r;
   logic                            resv_lost;

   // Command queue; a full queue holds cmd_wr_ready low, stalling the write
   ces_fifo #(.WIDTH($bits(ces_cmd_t)), .DEPTH(CMDQ_DEPTH)) u_cmdq (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .in_valid  (cmd_wr_valid),
      .in_data   (cmd_wr),
      .in_ready  (cmd_wr_ready),
      .out_valid (cmd_issue_valid),
      .out_data  (cmd_issue),
      .out_ready (cmd_issue_ready),
      .count     (cmdq_cnt)
   );
   assign cmdq_pop = clk_en && cmd_issue_valid && cmd_issue_ready;

   // Four-deep inbound mailbox, order kept by the FIFO
   ces_fifo #(.WIDTH(WORD_W), .DEPTH(INMBOX_DEPTH)) u_inmbox (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .in_valid  (inmbox_wr_valid),
      .in_data   (inmbox_wr_data),
      .in_ready  (inmbox_wr_ready),
      .out_valid (inmbox_valid),
      .out_data  (inmbox_head),
      .out_ready (inmbox_rd),
      .count     (inmbox_count)
   );
   assign inmbox_push = clk_en && inmbox_wr_valid && inmbox_wr_ready;

   // Mailbox read takes one entry and registers it
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         inmbox_rd_data_r <= WORD_RST;
      end else if (clk_en && inmbox_rd && inmbox_valid) begin
         inmbox_rd_data_r <= inmbox_head;
      end
   end

   // One-deep send mailboxes; full blocks the next core write
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         outmbox_full_r <= '0;
         outmbox_data_r <= '0;
      end else if (clk_en) begin
         for (int i = 0; i < OUTMBOX_NUM; i++) begin
            if (outmbox_wr[i] && !outmbox_full_r[i]) begin
               outmbox_full_r[i] <= 1'b1;
               outmbox_data_r[i] <= outmbox_wr_data[i];
            end else if (outmbox_rd[i]) begin
               outmbox_full_r[i] <= 1'b0;
            end
         end
      end
   end

   // Signal registers; a write in the same cycle as a read survives the clear
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sig_val_r     <= '0;
         sig_rd_data_r <= WORD_RST;
      end else if (clk_en) begin
         for (int i = 0; i < SIG_NUM; i++) begin
            if (sig_rd[i]) begin
               sig_rd_data_r <= sig_val_r[i];
            end
            if (sig_wr[i]) begin
               if (sig_or_mode[i] && !sig_rd[i]) begin
                  sig_val_r[i] <= sig_val_r[i] | sig_wr_data[i];
               end else begin
                  sig_val_r[i] <= sig_wr_data[i];
               end
            end else if (sig_rd[i]) begin
               sig_val_r[i] <= WORD_RST;
            end
         end
      end
   end

   // Reservation: an outside write into the line drops it, unless resv_set comes in the same cycle
   assign resv_lost = resv_valid_r && snoop_wr_valid &&
                      (snoop_wr_addr[ADDR_BITS-1:LINE_LSB] == resv_line_r);
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         resv_valid_r <= 1'b0;
         resv_line_r  <= '0;
      end else if (clk_en) begin
         if (resv_set) begin
            resv_valid_r <= 1'b1;
            resv_line_r  <= resv_addr[ADDR_BITS-1:LINE_LSB];
         end else if (resv_lost) begin
            resv_valid_r <= 1'b0;
         end
      end
   end

   // Event sources
   always_comb begin
      evt_set             = '0;
      evt_set[EVT_CMDQ]   = cmdq_pop;
      evt_set[EVT_INMBOX] = inmbox_push;
      evt_set[EVT_SIG1]   = sig_wr[0];
      evt_set[EVT_SIG2]   = sig_wr[1];
      evt_set[EVT_RESV]   = resv_lost;
      evt_set[EVT_ATTN]   = attn_set;
   end

   // Sticky flags; a new event beats an acknowledge in the same cycle
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         evt_pending_r <= EVT_RST;
      end else if (clk_en) begin
         evt_pending_r <= (evt_pending_r & ~evt_ack) | evt_set;
      end
   end

   assign evt_pending      = evt_pending_r;
   assign inmbox_rd_data   = inmbox_rd_data_r;
   assign sig_rd_data      = sig_rd_data_r;
   assign outmbox_full     = outmbox_full_r;
   assign outmbox_data     = outmbox_data_r;
   assign outmbox_wr_ready = ~outmbox_full_r;
   assign host_irq         = outmbox_full_r[OUT_INTR_IDX];
   assign resv_valid       = resv_valid_r;
   always_comb begin
      for (int i = 0; i < SIG_NUM; i++) begin
         sig_waiting[i] = (sig_val_r[i] != WORD_RST);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_sig1_or_write;
      clk_en && sig_wr[0] && sig_or_mode[0] && !sig_rd[0];
   endsequence
   sequence s_sig1_read_only;
      clk_en && sig_rd[0] && !sig_wr[0];
   endsequence

   property p_cmdq_max;
      cmdq_cnt <= CMDQ_DEPTH;
   endproperty
   a_cmdq_max: assert property (p_cmdq_max) else $error("command queue over depth");

   property p_cmdq_stall;
      (cmdq_cnt == CMDQ_DEPTH) |-> !cmd_wr_ready;
   endproperty
   a_cmdq_stall: assert property (p_cmdq_stall) else $error("full queue accepted write");

   property p_cmdq_avail;
      cmdq_pop |=> evt_pending[EVT_CMDQ] && cmd_wr_ready;
   endproperty
   a_cmdq_avail: assert property (p_cmdq_avail) else $error("no queue-available event");

   property p_inmbox_evt;
      inmbox_push |=> evt_pending[EVT_INMBOX] && (inmbox_count != 0);
   endproperty
   a_inmbox_evt: assert property (p_inmbox_evt) else $error("no inbound mailbox event");

   property p_sig_evt;
      clk_en && sig_wr[1] |=> evt_pending[EVT_SIG2] && (sig_val_r[1] != 0 || $past(sig_wr_data[1]) == 0);
   endproperty
   a_sig_evt: assert property (p_sig_evt) else $error("no signal 2 event");

   property p_sig_or;
      s_sig1_or_write |=> sig_val_r[0] == ($past(sig_val_r[0]) | $past(sig_wr_data[0]));
   endproperty
   a_sig_or: assert property (p_sig_or) else $error("OR mode did not merge");

   property p_resv_lost;
      clk_en && resv_lost && !resv_set |=> evt_pending[EVT_RESV] && !resv_valid;
   endproperty
   a_resv_lost: assert property (p_resv_lost) else $error("reservation loss missed");

   property p_attn;
      clk_en && attn_set |=> evt_pending[EVT_ATTN];
   endproperty
   a_attn: assert property (p_attn) else $error("no attention event");

   property p_sig_read_clear;
      (s_sig1_read_only and !sig_rd[1]) |=> sig_val_r[0] == 0 && sig_rd_data == $past(sig_val_r[0]);
   endproperty
   a_sig_read_clear: assert property (p_sig_read_clear) else $error("signal read did not clear");

   property p_evt_sticky;
      evt_pending[EVT_INMBOX] && !(clk_en && evt_ack[EVT_INMBOX]) |=> evt_pending[EVT_INMBOX];
   endproperty
   a_evt_sticky: assert property (p_evt_sticky) else $error("event dropped without ack");
endmodule

// ### test/ces_cmd_taker.sv
// Behavioural command taker on the issue side of the command queue
module ces_cmd_taker (
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              stall,
   input  wire logic              cmd_issue_valid,
   input  wire ces_pkg::ces_cmd_t cmd_issue,
   output logic                   cmd_issue_ready,
   output ces_pkg::ces_cmd_t      first_cmd,
   output int                     pops
);
   timeunit 1ns;
   timeprecision 1ps;
   import ces_pkg::*;
   // Ready follows the stall knob so the bench can keep the queue full
   assign cmd_issue_ready = !stall;
   // Count pops and keep the first one, which shows queue order
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pops <= 0;
      end else if (cmd_issue_valid && cmd_issue_ready) begin
         if (pops == 0) begin
            first_cmd <= cmd_issue;
         end
         pops <= pops + 1;
      end
   end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the core event source block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ces_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic cmd_wr_valid = 1'b0, cmd_wr_ready, cmd_issue_valid, cmd_issue_ready, stall = 1'b1;
   ces_cmd_t cmd_wr = '0, cmd_issue, first_cmd;
   int pops, errors = 0, num_checks = 0;
   logic inmbox_wr_valid = 1'b0, inmbox_wr_ready, inmbox_rd = 1'b0, host_irq;
   logic [WORD_W-1:0] inmbox_wr_data = '0, inmbox_rd_data, sig_rd_data;
   logic [2:0] inmbox_count;
   logic [1:0] outmbox_wr = '0, outmbox_wr_ready, outmbox_rd = '0, outmbox_full;
   logic [1:0][WORD_W-1:0] outmbox_wr_data = '0, outmbox_data, sig_wr_data = '0;
   logic [1:0] sig_or_mode = 2'h1, sig_wr = '0, sig_rd = '0, sig_waiting;
   logic resv_set = 1'b0, snoop_wr_valid = 1'b0, resv_valid, attn_set = 1'b0;
   logic [63:0] resv_addr = '0, snoop_wr_addr = '0;
   logic [EVT_NUM-1:0] evt_ack = '0, evt_pending;
   // Free-running system clock, 25 ns period
   always #12.5 clk_sys = ~clk_sys;
   ces_core_events DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .cmd_wr_valid(cmd_wr_valid),
      .cmd_wr(cmd_wr), .cmd_wr_ready(cmd_wr_ready), .cmd_issue_valid(cmd_issue_valid), .cmd_issue(cmd_issue),
      .cmd_issue_ready(cmd_issue_ready), .inmbox_wr_valid(inmbox_wr_valid), .inmbox_wr_data(inmbox_wr_data),
      .inmbox_wr_ready(inmbox_wr_ready), .inmbox_rd(inmbox_rd), .inmbox_rd_data(inmbox_rd_data),
      .inmbox_count(inmbox_count), .outmbox_wr(outmbox_wr), .outmbox_wr_data(outmbox_wr_data),
      .outmbox_wr_ready(outmbox_wr_ready), .outmbox_rd(outmbox_rd), .outmbox_data(outmbox_data),
      .outmbox_full(outmbox_full), .host_irq(host_irq), .sig_or_mode(sig_or_mode), .sig_wr(sig_wr),
      .sig_wr_data(sig_wr_data), .sig_rd(sig_rd), .sig_rd_data(sig_rd_data), .sig_waiting(sig_waiting),
      .resv_set(resv_set), .resv_addr(resv_addr), .snoop_wr_valid(snoop_wr_valid), .snoop_wr_addr(snoop_wr_addr),
      .resv_valid(resv_valid), .attn_set(attn_set), .evt_ack(evt_ack), .evt_pending(evt_pending));
   ces_cmd_taker u_taker (.clk_sys(clk_sys), .sys_rst(sys_rst), .stall(stall), .cmd_issue_valid(cmd_issue_valid),
      .cmd_issue(cmd_issue), .cmd_issue_ready(cmd_issue_ready), .first_cmd(first_cmd), .pops(pops));
   // Inputs move a fixed 2 ns after the edge, clear of sampling
   task automatic step();
      @(posedge clk_sys);
      #2;
   endtask
   task automatic chk(logic [WORD_W-1:0] got, logic [WORD_W-1:0] exp, string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic ack(int idx);
      evt_ack = 6'h01 << idx;
      step();
      evt_ack = '0;
      chk(32'(evt_pending[idx]), 32'h1 & 32'h0, "event cleared by ack");
   endtask
   // Fill the queue past sixteen with the taker stalled, then release it
   task automatic t_cmdq();
      cmd_wr_valid = 1'b1;
      for (int i = 0; i < CMDQ_DEPTH; i++) begin
         cmd_wr = '{class_id: 8'(i + 1), opcode: 16'(i + 16'hA0)};
         step();
      end
      cmd_wr = '{class_id: 8'hEE, opcode: 16'hBEEF};
      chk(32'(cmd_wr_ready), 32'h0, "queue full after sixteen");
      step();
      step();
      chk(32'(cmd_wr_ready), 32'h0, "write still stalled");
      chk(32'(evt_pending[EVT_CMDQ]), 32'h0, "no space event while full");
      stall = 1'b0;
      step();
      chk(32'(cmd_wr_ready), 32'h1, "space after one pop");
      chk(32'(evt_pending[EVT_CMDQ]), 32'h1, "space event");
      step();
      cmd_wr_valid = 1'b0;
      for (int n = 0; n < 40 && cmd_issue_valid !== 1'b0; n++) step();
      chk(32'(pops), 32'd17, "stalled write completed");
      chk(32'(first_cmd), 32'h0100A0, "queue order");
      stall = 1'b1;
      ack(EVT_CMDQ);
      $display("test cmdq done");
   endtask
   // Fill the receive mailbox until refused, then drain in order
   task automatic t_inmbox();
      inmbox_wr_valid = 1'b1;
      for (int i = 0; i < 5; i++) begin
         inmbox_wr_data = 32'hC0DE0000 + 32'(i);
         step();
      end
      inmbox_wr_valid = 1'b0;
      chk(32'(inmbox_wr_ready), 32'h0, "mailbox refuses fifth");
      chk(32'(inmbox_count), 32'd4, "mailbox depth");
      chk(32'(evt_pending[EVT_INMBOX]), 32'h1, "mailbox event");
      inmbox_rd = 1'b1;
      for (int i = 0; i < INMBOX_DEPTH; i++) begin
         step();
         chk(inmbox_rd_data, 32'hC0DE0000 + 32'(i), "mailbox word order");
      end
      inmbox_rd = 1'b0;
      chk(32'(inmbox_count), 32'd0, "read removes entries");
      ack(EVT_INMBOX);
      $display("test inmbox done");
   endtask
   // Register 1 in OR mode, register 2 in overwrite mode
   task automatic t_sig();
      sig_wr = 2'h3;
      sig_wr_data = {32'h1, 32'h1};
      step();
      sig_wr_data = {32'h4, 32'h4};
      step();
      sig_wr = 2'h0;
      chk(32'(evt_pending[EVT_SIG2:EVT_SIG1]), 32'h3, "signal events");
      chk(32'(sig_waiting), 32'h3, "signals waiting");
      sig_rd = 2'h1;
      step();
      sig_rd = 2'h2;
      chk(sig_rd_data, 32'h5, "OR accumulate");
      step();
      sig_rd = 2'h0;
      chk(sig_rd_data, 32'h4, "overwrite mode");
      chk(32'(sig_waiting), 32'h0, "read clears signal");
      $display("test sig done");
   endtask
   // Outside write in another line, then inside the line; then attention
   task automatic t_resv_attn();
      resv_addr = 64'h1000;
      resv_set = 1'b1;
      step();
      resv_set = 1'b0;
      snoop_wr_addr = 64'h1080;
      snoop_wr_valid = 1'b1;
      step();
      chk(32'(evt_pending[EVT_RESV]), 32'h0, "other line keeps reservation");
      snoop_wr_addr = 64'h107F;
      step();
      snoop_wr_valid = 1'b0;
      attn_set = 1'b1;
      chk(32'(evt_pending[EVT_RESV]), 32'h1, "reservation lost");
      chk(32'(resv_valid), 32'h0, "reservation dropped");
      step();
      attn_set = 1'b0;
      chk(32'(evt_pending[EVT_ATTN]), 32'h1, "attention event");
      step();
      chk(32'(evt_pending[EVT_ATTN]), 32'h1, "attention stays pending");
      $display("test resv_attn done");
   endtask
   // Two one-deep send mailboxes, only the second one interrupts
   task automatic t_outmbox();
      outmbox_wr = 2'h1;
      outmbox_wr_data = {32'h22222222, 32'h11111111};
      step();
      outmbox_wr = 2'h2;
      chk(32'(outmbox_full), 32'h1, "box one full");
      chk(32'(outmbox_wr_ready), 32'h2, "box one refuses writes");
      chk(32'(host_irq), 32'h0, "box one quiet");
      step();
      outmbox_wr = 2'h1;
      outmbox_wr_data = {32'h22222222, 32'h33333333};
      chk(32'(host_irq), 32'h1, "box two interrupts");
      step();
      outmbox_wr = 2'h0;
      outmbox_rd = 2'h3;
      chk(outmbox_data[0], 32'h11111111, "one-deep refuses");
      step();
      outmbox_rd = 2'h0;
      chk(32'(outmbox_full), 32'h0, "host read empties");
      $display("test outmbox done");
   endtask
   // Low enable freezes the block; the held write lands once enabled
   task automatic t_freeze();
      clk_en = 1'b0;
      inmbox_wr_valid = 1'b1;
      inmbox_wr_data = 32'h5A5A0001;
      step();
      chk(32'(inmbox_count), 32'd0, "frozen mailbox");
      chk(32'(evt_pending[EVT_INMBOX]), 32'h0, "no event while frozen");
      clk_en = 1'b1;
      step();
      inmbox_wr_valid = 1'b0;
      chk(32'(inmbox_count), 32'd1, "write after enable");
      chk(32'(evt_pending[EVT_INMBOX]), 32'h1, "event after enable");
      inmbox_rd = 1'b1;
      step();
      inmbox_rd = 1'b0;
      chk(inmbox_rd_data, 32'h5A5A0001, "frozen word kept");
      $display("test freeze done");
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge clk_sys);
      #2;
      sys_rst = 1'b0;
      chk(32'({cmd_wr_ready, inmbox_wr_ready, outmbox_wr_ready, host_irq}), 32'h1E, "reset ready");
      chk(32'(evt_pending), 32'(EVT_RST), "reset events");
      t_cmdq();
      t_inmbox();
      t_sig();
      t_resv_attn();
      t_outmbox();
      t_freeze();
      summarize();
   end
   // Watchdog well past the under a hundred cycles the tests need
   initial begin
      #125000;
      errors++;
      summarize();
   end
endmodule
